//--- hw/cpri_link_config_control.sv
// Purpose: configuration registers, start-up sequencing and frame numbering
// Assumes: APB master per the published protocol; one wait state per access
// Notes: link_up arrives from a pin and is synchronised before use
`timescale 1ns/1ps
`default_nettype none
module cpri_link_config_control #(
	parameter cpri_cfg_pkg::eth_mode_t ETH_MODE = cpri_cfg_pkg::ETH_SERIAL
) (
	input wire logic core_clk, // core clock, 200 MHz
	input wire logic nrst, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic link_up, // layer 1 sync from pin
	input wire logic [4:0] far_hdlc_enable, // far end permitted hdlc rates
	input wire logic hyperframe_tick, // end of each transmit hyperframe
	input wire logic outbound_frame_strobe, // transmit sync strobe
	output cpri_cfg_pkg::startup_t startup_state, // start-up machine state
	output logic [1:0] line_rate, // negotiated line rate code
	output logic phy_reconfig_request, // physical layer must change mode
	output logic [4:0] hdlc_advertise, // hdlc rates offered to far end
	output logic [2:0] hdlc_rate, // chosen hdlc option, 0 off
	output logic [5:0] fast_cm_offset, // fast c&m pointer
	output logic radio_controller_role, // 1 controller, 0 equipment
	output logic [7:0] hyperframe_num, // transmit hyperframe number
	output logic [11:0] node_frame_num // transmit node-frame number
);
	import cpri_cfg_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [11:0] dwell(input logic accel);
		dwell = accel ? DWELL_TEST_CYC : DWELL_CYC;
	endfunction

	// highest option set in the mask, 0 when empty
	function automatic logic [2:0] best_hdlc(input logic [4:0] m);
		best_hdlc = HDLC_OFF;
		for (int i = 0; i < 5; i++) begin
			if (m[i]) begin
				best_hdlc = 3'(i + 1);
			end
		end
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'h0) && (a <= OFS_FRAME);
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	cfg_t cfg_q, cfg_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic hf_load, nf_load;
	logic link_meta_q, link_q;
	logic sf_prev_q;
	startup_t st_q, st_d;
	logic [11:0] tmr_q, tmr_d;
	logic [1:0] rate_q, rate_d;
	logic recfg_q, recfg_d;
	logic [2:0] hdlc_q, hdlc_d;
	logic [7:0] hf_q, hf_d;
	logic [11:0] nf_q, nf_d;
	logic access;
	logic sf_edge;

	assign access = psel & penable;
	assign sf_edge = cfg_q.standby_force & ~sf_prev_q;

	// ------------------------------------------------------------
	// apb slave and configuration registers
	// ------------------------------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		hf_load = 1'b0;
		nf_load = 1'b0;
		// first access cycle prepares the answer, second completes it
		if (access & ~pready_q) begin
			pready_d = 1'b1;
			pslverr_d = ~is_mapped(paddr);
			prdata_d = 32'h0;
			if (!pwrite) begin
				if (paddr == OFS_CTRL) begin
					prdata_d[CTRL_LINK_EN] = cfg_q.link_enable;
					prdata_d[CTRL_STANDBY] = cfg_q.standby_force;
					prdata_d[CTRL_ACCEL] = cfg_q.timer_accelerate;
					prdata_d[CTRL_ROLE] = cfg_q.radio_controller_role;
					prdata_d[CTRL_AUTO] = cfg_q.frame_number_autoadvance;
					prdata_d[CTRL_HF_ALLOW] = cfg_q.hyperframe_sync_reset_allow;
					prdata_d[CTRL_NF_ALLOW] = cfg_q.node_frame_sync_reset_allow;
				end else if (paddr == OFS_RATE) begin
					prdata_d[RATE_MAX_LSB +: 2] = cfg_q.max_rate_select;
					prdata_d[RATE_PHY_LSB +: 2] = cfg_q.phy_rate_select;
				end else if (paddr == OFS_HDLC) begin
					prdata_d[4:0] = cfg_q.hdlc_enable;
				end else if (paddr == OFS_ETH) begin
					prdata_d[7:0] = cfg_q.fast_cm_offset;
				end else if (paddr == OFS_HF_SEED) begin
					prdata_d[7:0] = cfg_q.hyperframe_seed;
				end else if (paddr == OFS_NF_SEED) begin
					prdata_d[11:0] = cfg_q.node_frame_seed;
				end else if (paddr == OFS_STATUS) begin
					prdata_d[2:0] = st_q;
					prdata_d[STAT_RATE_LSB +: 2] = rate_q;
					prdata_d[STAT_RECFG] = recfg_q;
					prdata_d[STAT_LINK] = link_q;
					prdata_d[STAT_HDLC_LSB +: 3] = hdlc_q;
					prdata_d[STAT_ETH_LSB +: 2] = ETH_MODE;
					prdata_d[STAT_LOWLAT] = LOW_LATENCY_ONLY;
				end else if (paddr == OFS_FRAME) begin
					prdata_d[7:0] = hf_q;
					prdata_d[FRAME_NF_LSB +: 12] = nf_q;
				end
			end
		end
		if (access & pready_q & pwrite) begin
			if (paddr == OFS_CTRL) begin
				cfg_d.link_enable = pwdata[CTRL_LINK_EN];
				cfg_d.standby_force = pwdata[CTRL_STANDBY];
				cfg_d.timer_accelerate = pwdata[CTRL_ACCEL];
				cfg_d.radio_controller_role = pwdata[CTRL_ROLE];
				cfg_d.frame_number_autoadvance = pwdata[CTRL_AUTO];
				cfg_d.hyperframe_sync_reset_allow = pwdata[CTRL_HF_ALLOW];
				cfg_d.node_frame_sync_reset_allow = pwdata[CTRL_NF_ALLOW];
			end else if (paddr == OFS_RATE) begin
				cfg_d.max_rate_select = pwdata[RATE_MAX_LSB +: 2];
				cfg_d.phy_rate_select = pwdata[RATE_PHY_LSB +: 2];
			end else if (paddr == OFS_HDLC) begin
				cfg_d.hdlc_enable = pwdata[4:0];
			end else if (paddr == OFS_ETH) begin
				cfg_d.fast_cm_offset = pwdata[7:0];
			end else if (paddr == OFS_HF_SEED) begin
				cfg_d.hyperframe_seed = pwdata[7:0];
				hf_load = 1'b1;
			end else if (paddr == OFS_NF_SEED) begin
				cfg_d.node_frame_seed = pwdata[11:0];
				nf_load = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= '0;
			cfg_q.frame_number_autoadvance <= AUTO_RST;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			cfg_q <= cfg_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// ------------------------------------------------------------
	// start-up sequencing
	// ------------------------------------------------------------
	// a forced standby must beat every other transition
	always_comb begin
		st_d = st_q;
		tmr_d = (tmr_q == 12'h0) ? 12'h0 : tmr_q - 12'h1;
		rate_d = rate_q;
		recfg_d = recfg_q;
		hdlc_d = hdlc_q;
		if (sf_edge | ~cfg_q.link_enable) begin
			st_d = ST_STANDBY;
			recfg_d = 1'b0;
			hdlc_d = HDLC_OFF;
		end else begin
			case (st_q)
				ST_STANDBY: begin
					rate_d = cfg_q.max_rate_select;
					st_d = ST_RATE_NEG;
				end
				ST_RATE_NEG: begin
					// hold the request until the phy reports our rate
					if (cfg_q.phy_rate_select == rate_q) begin
						recfg_d = 1'b0;
						st_d = ST_L1_SYNC;
						tmr_d = dwell(cfg_q.timer_accelerate);
					end else begin
						recfg_d = 1'b1;
					end
				end
				ST_L1_SYNC: begin
					if (link_q) begin
						st_d = ST_PROTO;
						tmr_d = dwell(cfg_q.timer_accelerate);
					end else if (tmr_q == 12'h0) begin
						// step down; from lowest wrap back to the cap
						rate_d = (rate_q == RATE_614) ?
							cfg_q.max_rate_select : rate_q - 2'h1;
						st_d = ST_RATE_NEG;
					end
				end
				ST_PROTO: begin
					if (!link_q) begin
						st_d = ST_L1_SYNC;
						tmr_d = dwell(cfg_q.timer_accelerate);
					end else if (tmr_q == 12'h0) begin
						st_d = ST_CM;
					end
				end
				ST_CM: begin
					hdlc_d = best_hdlc(cfg_q.hdlc_enable & far_hdlc_enable);
					st_d = ST_OPERATION;
				end
				ST_OPERATION: begin
					hdlc_d = best_hdlc(cfg_q.hdlc_enable & far_hdlc_enable);
					if (!link_q) begin
						st_d = ST_L1_SYNC;
						tmr_d = dwell(cfg_q.timer_accelerate);
					end
				end
				default: begin
					st_d = ST_STANDBY;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			link_meta_q <= 1'b0;
			link_q <= 1'b0;
			sf_prev_q <= 1'b0;
			st_q <= ST_STANDBY;
			tmr_q <= 12'h0;
			rate_q <= RATE_RST;
			recfg_q <= 1'b0;
			hdlc_q <= HDLC_OFF;
		end else begin
			link_meta_q <= link_up;
			link_q <= link_meta_q;
			sf_prev_q <= cfg_q.standby_force;
			st_q <= st_d;
			tmr_q <= tmr_d;
			rate_q <= rate_d;
			recfg_q <= recfg_d;
			hdlc_q <= hdlc_d;
		end
	end

	// ------------------------------------------------------------
	// transmit frame numbering
	// ------------------------------------------------------------
	// strobe clear beats seed load and counting
	always_comb begin
		hf_d = hf_q;
		nf_d = nf_q;
		if (outbound_frame_strobe & cfg_q.hyperframe_sync_reset_allow) begin
			hf_d = 8'h0;
		end else if (!cfg_q.frame_number_autoadvance) begin
			hf_d = cfg_q.hyperframe_seed;
		end else if (hf_load) begin
			hf_d = cfg_d.hyperframe_seed;
		end else if (hyperframe_tick) begin
			hf_d = (hf_q >= HF_LAST) ? 8'h0 : hf_q + 8'h1;
		end
		if (outbound_frame_strobe & cfg_q.node_frame_sync_reset_allow) begin
			nf_d = 12'h0;
		end else if (!cfg_q.frame_number_autoadvance) begin
			nf_d = cfg_q.node_frame_seed;
		end else if (nf_load) begin
			nf_d = cfg_d.node_frame_seed;
		end else if (hyperframe_tick && hf_q >= HF_LAST) begin
			nf_d = (nf_q == NF_LAST) ? 12'h0 : nf_q + 12'h1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hf_q <= 8'h0;
			nf_q <= 12'h0;
		end else begin
			hf_q <= hf_d;
			nf_q <= nf_d;
		end
	end

	// ------------------------------------------------------------
	// outputs, all from flops
	// ------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign startup_state = st_q;
	assign line_rate = rate_q;
	assign phy_reconfig_request = recfg_q;
	assign hdlc_advertise = cfg_q.hdlc_enable;
	assign hdlc_rate = hdlc_q;
	assign fast_cm_offset = cfg_q.fast_cm_offset[5:0];
	assign radio_controller_role = cfg_q.radio_controller_role;
	assign hyperframe_num = hf_q;
	assign node_frame_num = nf_q;

endmodule
`default_nettype wire

//--- include/cpri_cfg_pkg.sv
// Purpose: constants and types of the link configuration and control block
// Assumes: 200 MHz core clock, APB register access with 32-bit data
// Notes: every offset, field position above bit 0, non-zero reset value, dwell and frame count is named here
package cpri_cfg_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int DWELL_NS = 10000;
	localparam int DWELL_TEST_NS = 100;
	localparam logic [11:0] DWELL_CYC = 12'((DWELL_NS * CLK_MHZ) / 1000);
	localparam logic [11:0] DWELL_TEST_CYC =
		12'((DWELL_TEST_NS * CLK_MHZ) / 1000);

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RATE = 8'h04;
	localparam logic [7:0] OFS_HDLC = 8'h08;
	localparam logic [7:0] OFS_ETH = 8'h0c;
	localparam logic [7:0] OFS_HF_SEED = 8'h10;
	localparam logic [7:0] OFS_NF_SEED = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_FRAME = 8'h1c;

	// register fields
	localparam int CTRL_LINK_EN = 0;
	localparam int CTRL_STANDBY = 1;
	localparam int CTRL_ACCEL = 2;
	localparam int CTRL_ROLE = 3;
	localparam int CTRL_AUTO = 4;
	localparam int CTRL_HF_ALLOW = 5;
	localparam int CTRL_NF_ALLOW = 6;
	localparam int RATE_MAX_LSB = 0;
	localparam int RATE_PHY_LSB = 3;
	localparam int FRAME_NF_LSB = 8;
	localparam int STAT_RATE_LSB = 3;
	localparam int STAT_RECFG = 5;
	localparam int STAT_LINK = 6;
	localparam int STAT_HDLC_LSB = 7;
	localparam int STAT_ETH_LSB = 10;
	localparam int STAT_LOWLAT = 12;

	// reset values
	localparam logic AUTO_RST = 1'b1;
	localparam logic [1:0] RATE_RST = 2'h0;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [1:0] RATE_614 = 2'h0;
	localparam logic [7:0] HF_LAST = 8'h95;
	localparam logic [11:0] NF_LAST = 12'hfff;
	localparam logic LOW_LATENCY_ONLY = 1'b1;
	localparam logic [2:0] HDLC_OFF = 3'h0;

	typedef enum logic [1:0] {
		ETH_SERIAL,
		ETH_MII_MATCHED,
		ETH_MII_100
	} eth_mode_t;

	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_RATE_NEG,
		ST_L1_SYNC,
		ST_PROTO,
		ST_CM,
		ST_OPERATION
	} startup_t;

	typedef struct packed {
		logic link_enable;
		logic standby_force;
		logic timer_accelerate;
		logic radio_controller_role;
		logic frame_number_autoadvance;
		logic hyperframe_sync_reset_allow;
		logic node_frame_sync_reset_allow;
		logic [1:0] max_rate_select;
		logic [1:0] phy_rate_select;
		logic [4:0] hdlc_enable;
		logic [7:0] fast_cm_offset;
		logic [7:0] hyperframe_seed;
		logic [11:0] node_frame_seed;
	} cfg_t;

endpackage

//--- tb/cpri_cfg_chk.sv
// Purpose: port-level checks of the config and control block
// Assumes: apb with one wait state, registered outputs
// Notes: keeps a shadow of CTRL to know the allow and standby bits
`timescale 1ns/1ps
`default_nettype none
module cpri_cfg_chk (
	input wire logic core_clk, // core clock
	input wire logic nrst, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic [4:0] far_hdlc_enable, // far end rates
	input wire logic outbound_frame_strobe, // tx sync
	input wire cpri_cfg_pkg::startup_t startup_state, // machine state
	input wire logic [4:0] hdlc_advertise, // offered rates
	input wire logic [2:0] hdlc_rate, // chosen rate
	input wire logic [5:0] fast_cm_offset, // c&m pointer
	input wire logic radio_controller_role, // role
	input wire logic [7:0] hyperframe_num, // hf number
	input wire logic [11:0] node_frame_num // nf number
);
	import cpri_cfg_pkg::*;
	logic [6:0] ctrl_q;
	logic [6:0] ctrl_d;
	logic wr_ok;
	logic [4:0] common;
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	assign common = hdlc_advertise & far_hdlc_enable;
	// highest option both ends permit, 0 when none
	function automatic logic [2:0] top_hdlc(input logic [4:0] m);
		if (m[4])
			top_hdlc = 3'h5;
		else if (m[3])
			top_hdlc = 3'h4;
		else if (m[2])
			top_hdlc = 3'h3;
		else if (m[1])
			top_hdlc = 3'h2;
		else if (m[0])
			top_hdlc = 3'h1;
		else
			top_hdlc = 3'h0;
	endfunction
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ok && paddr == OFS_CTRL)
			ctrl_d = pwdata[6:0];
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			ctrl_q <= 7'h10;
		else
			ctrl_q <= ctrl_d;
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	AST_UNMAPPED: assert property
		(pready && (paddr > OFS_FRAME || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped access without error");
	AST_STANDBY: assert property (wr_ok && paddr == OFS_CTRL &&
		pwdata[CTRL_STANDBY] && !ctrl_q[CTRL_STANDBY]
		|-> ##[1:2] startup_state == ST_STANDBY)
		else $error("standby not forced");
	AST_OFFSET: assert property (wr_ok && paddr == OFS_ETH
		|=> fast_cm_offset == $past(pwdata[5:0]))
		else $error("pointer not taken");
	AST_ROLE: assert property (wr_ok && paddr == OFS_CTRL
		|=> radio_controller_role == $past(pwdata[CTRL_ROLE]))
		else $error("role not taken");
	AST_HDLC_PICK: assert property (startup_state == ST_OPERATION &&
		($past(startup_state) == ST_CM ||
		$past(startup_state) == ST_OPERATION)
		|-> hdlc_rate == top_hdlc($past(common)))
		else $error("hdlc choice wrong");
	AST_HF_CLEAR: assert property (outbound_frame_strobe &&
		ctrl_q[CTRL_HF_ALLOW] |=> hyperframe_num == 8'h0)
		else $error("hyperframe not cleared");
	AST_NF_CLEAR: assert property (outbound_frame_strobe &&
		ctrl_q[CTRL_NF_ALLOW] |=> node_frame_num == 12'h0)
		else $error("node frame not cleared");
	cover property (wr_ok);
	cover property (startup_state == ST_OPERATION);
	cover property (outbound_frame_strobe && ctrl_q[CTRL_NF_ALLOW]);
endmodule
bind cpri_link_config_control cpri_cfg_chk u_chk (.core_clk, .nrst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .far_hdlc_enable,
	.outbound_frame_strobe, .startup_state, .hdlc_advertise, .hdlc_rate,
	.fast_cm_offset, .radio_controller_role, .hyperframe_num, .node_frame_num);
`default_nettype wire

//--- tb/cpri_app_model.sv
// Purpose: user logic and line partner around the config block
// Assumes: same core clock, pulses asked for by the bench
// Notes: lock comes late when slow is set, still inside the timer
`timescale 1ns/1ps
`default_nettype none
module cpri_app_model (
	input wire logic core_clk, // core clock
	input wire logic nrst, // reset, active low
	input wire cpri_cfg_pkg::startup_t startup_state, // machine state
	input wire logic slow, // late lock
	input wire logic tick_req, // one tick wanted
	input wire logic strobe_req, // one strobe wanted
	output logic link_up, // layer 1 locked
	output logic hyperframe_tick, // tick pulse
	output logic outbound_frame_strobe // sync pulse
);
	import cpri_cfg_pkg::*;
	logic [5:0] lock_cnt;
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lock_cnt <= 6'h0;
			link_up <= 1'b0;
			hyperframe_tick <= 1'b0;
			outbound_frame_strobe <= 1'b0;
		end else begin
			hyperframe_tick <= tick_req;
			outbound_frame_strobe <= strobe_req;
			// lock lost whenever the link restarts
			if (startup_state == ST_STANDBY || startup_state == ST_RATE_NEG) begin
				lock_cnt <= 6'h0;
				link_up <= 1'b0;
			end else if (lock_cnt == (slow ? 6'hc : 6'h2))
				link_up <= 1'b1;
			else
				lock_cnt <= lock_cnt + 6'h1;
		end
	end
endmodule
`default_nettype wire

//--- tb/cpri_link_config_control_tb_top.sv
// Purpose: register, start-up and frame number tests of the block
// Assumes: apb one access at a time, partner model for line side
// Notes: phy rate reprogrammed by the bench on each reconfig request
`timescale 1ns/1ps
`default_nettype none
module cpri_link_config_control_tb_top;
	import cpri_cfg_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, link_up, hyperframe_tick, outbound_frame_strobe;
	logic [4:0] far_hdlc_enable = 5'h1a;
	logic [4:0] hdlc_advertise;
	logic slow = 1'b0;
	logic tick_req = 1'b0;
	logic strobe_req = 1'b0;
	logic seen;
	startup_t startup_state;
	logic [1:0] line_rate, max_r;
	logic phy_reconfig_request, radio_controller_role;
	logic [2:0] hdlc_rate;
	logic [5:0] fast_cm_offset;
	logic [7:0] hyperframe_num;
	logic [11:0] node_frame_num;
	int n_fail = 0;
	int checks_done = 0;
	int t0;
	int n_rq;
	always #2.5 core_clk = ~core_clk;
	cpri_link_config_control DUT (.core_clk, .nrst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link_up, .far_hdlc_enable,
		.hyperframe_tick, .outbound_frame_strobe, .startup_state, .line_rate,
		.phy_reconfig_request, .hdlc_advertise, .hdlc_rate, .fast_cm_offset,
		.radio_controller_role, .hyperframe_num, .node_frame_num);
	cpri_app_model app (.core_clk, .nrst, .startup_state, .slow, .tick_req,
		.strobe_req, .link_up, .hyperframe_tick, .outbound_frame_strobe);
	// ---------------------------------------------------------
	// tasks
	// ---------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("mismatch %0t apb answer missing", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input logic t);
		@(posedge core_clk);
		tick_req <= t;
		strobe_req <= !t;
		@(posedge core_clk);
		tick_req <= 1'b0;
		strobe_req <= 1'b0;
	endtask
	// waits for a state, answering reconfig requests; counts dwell cycles
	task automatic run_to(input startup_t s);
		int n;
		n = 0;
		t0 = 0;
		n_rq = 0;
		while (startup_state !== s && n < 8000) begin
			if (phy_reconfig_request === 1'b1) begin
				n_rq++;
				apb(1'b1, OFS_RATE, {27'h0, line_rate, 1'b0, max_r});
			end else begin
				@(posedge core_clk);
			end
			if (startup_state === ST_PROTO)
				t0++;
			n++;
		end
		chk({31'h0, n < 8000}, 32'h1);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ---------------------------------------------------------
	// tests
	// ---------------------------------------------------------
	initial begin
		#100000;
		n_fail++;
		$display("mismatch %0t watchdog expired", $time);
		conclude();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h10);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h1000);
		apb(1'b0, 8'h20, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, 8'h0d, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, OFS_ETH, 32'hff);
		apb(1'b0, OFS_ETH, 32'h0);
		chk(rd, 32'hff);
		chk({26'h0, fast_cm_offset}, 32'h3f);
		// frame numbers with link idle: seed loads, one wrapping tick and strobe clears
		apb(1'b1, OFS_FRAME, 32'hffffffff);
		chk({31'h0, err}, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_HF_SEED, 32'h95);
		apb(1'b1, OFS_NF_SEED, 32'hfff);
		apb(1'b0, OFS_FRAME, 32'h0);
		chk(rd, 32'hfff95);
		chk({12'h0, node_frame_num, hyperframe_num}, 32'hfff95);
		apb(1'b1, OFS_CTRL, 32'h10);
		pulse(1'b1);
		apb(1'b0, OFS_FRAME, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, OFS_HF_SEED, 32'h10);
		apb(1'b1, OFS_NF_SEED, 32'h20);
		apb(1'b1, OFS_CTRL, 32'h30);
		pulse(1'b0);
		apb(1'b0, OFS_FRAME, 32'h0);
		chk(rd, 32'h2000);
		chk({12'h0, node_frame_num, hyperframe_num}, 32'h2000);
		apb(1'b1, OFS_HF_SEED, 32'h10);
		apb(1'b1, OFS_CTRL, 32'h50);
		pulse(1'b0);
		apb(1'b0, OFS_FRAME, 32'h0);
		chk(rd, 32'h10);
		// link bring-up, accelerated timers, controller role
		max_r = 2'h2;
		apb(1'b1, OFS_HDLC, 32'hb);
		apb(1'b1, OFS_RATE, 32'h2);
		apb(1'b1, OFS_CTRL, 32'h1d);
		run_to(ST_OPERATION);
		chk({30'h0, line_rate}, 32'h2);
		chk({29'h0, hdlc_rate}, 32'h4);
		chk({27'h0, hdlc_advertise}, 32'hb);
		chk({31'h0, radio_controller_role}, 32'h1);
		chk({31'h0, t0 < 100}, 32'h1);
		chk({31'h0, n_rq > 0}, 32'h1);
		// forced restart, no hdlc, normal timers, late lock
		apb(1'b1, OFS_HDLC, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h13);
		seen = 1'b0;
		repeat (3) begin
			@(posedge core_clk);
			if (startup_state === ST_STANDBY)
				seen = 1'b1;
		end
		chk({31'h0, seen}, 32'h1);
		slow <= 1'b1;
		run_to(ST_OPERATION);
		chk({31'h0, t0 > 1000}, 32'h1);
		chk({31'h0, n_rq == 0}, 32'h1);
		chk({29'h0, hdlc_rate}, 32'h0);
		chk({27'h0, hdlc_advertise}, 32'h0);
		chk({31'h0, radio_controller_role}, 32'h0);
		// reset again mid-run: outputs idle, defaults back
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		chk({27'h0, startup_state, line_rate}, 32'h0);
		chk({28'h0, phy_reconfig_request, hdlc_rate}, 32'h0);
		chk({12'h0, node_frame_num, hyperframe_num}, 32'h0);
		chk({21'h0, hdlc_advertise, fast_cm_offset}, 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h10);
		conclude();
	end
endmodule
`default_nettype wire
